/* core/cps_pkg.sv */
// constants and types for the cell protection state machine
package cps_pkg;
    localparam int unsigned CLK_HZ        = 125_000_000;
    localparam int unsigned OSC_HZ        = 7_500;
    localparam int unsigned TICK_CYCLES   = CLK_HZ / OSC_HZ;
    localparam int unsigned OV_QUAL_US    = 2_000;
    localparam int unsigned UV_QUAL_US    = 1_000;
    localparam int unsigned OV_QUAL_TICKS = (OV_QUAL_US * OSC_HZ + 999_999) / 1_000_000;
    localparam int unsigned UV_QUAL_TICKS = (UV_QUAL_US * OSC_HZ + 999_999) / 1_000_000;
    localparam int unsigned TRIP_NS       = 100_000;
    localparam int unsigned TRIP_CYCLES   = TRIP_NS / 8;
    localparam int unsigned QUAL_W        = 5;
    localparam int unsigned TRIP_W        = 24;

    localparam logic [7:0]  ADDR_CTRL     = 8'h00;
    localparam logic [7:0]  ADDR_STATUS   = 8'h04;
    localparam logic [7:0]  ADDR_IRQ_STAT = 8'h08;
    localparam logic [7:0]  ADDR_IRQ_MASK = 8'h0C;
    localparam logic [7:0]  ADDR_TRIP_EXT = 8'h10;

    localparam int unsigned CTRL_FORCE_OFF = 0;
    localparam logic [31:0] CTRL_RESET     = 32'h0000_0000;
    localparam logic [15:0] TRIP_EXT_RESET = 16'h0000;
    localparam logic [4:0]  MASK_RESET     = 5'h00;

    localparam int unsigned EV_OVERCHARGE = 0;
    localparam int unsigned EV_UNDER      = 1;
    localparam int unsigned EV_BOTH       = 2;
    localparam int unsigned EV_TRIP       = 3;
    localparam int unsigned EV_WARN       = 4;
    localparam int unsigned EV_N          = 5;

    typedef enum logic [4:0] {
        ST_NORMAL = 5'b00001,
        ST_OVER   = 5'b00010,
        ST_UNDER  = 5'b00100,
        ST_BOTH   = 5'b01000,
        ST_TRIP   = 5'b10000
    } cps_state_t;

    typedef enum logic [1:0] {
        SW_OFF       = 2'h0,
        SW_DISCHARGE = 2'h1,
        SW_CHARGE    = 2'h2,
        SW_BOTH      = 2'h3
    } cps_sw_t;

    typedef struct packed {
        logic [1:0] above_over;
        logic [1:0] above_rec;
        logic [1:0] below_warn;
        logic [1:0] below_under;
        logic       overcurrent;
        logic       load_present;
        logic       charger_present;
        logic       assembly_en;
    } cps_sense_t;

    localparam int unsigned SENSE_W = $bits(cps_sense_t);
endpackage : cps_pkg

/* core/cps_sync.sv */
// two-flop synchroniser bank
`timescale 1ns/100ps
module cps_sync #(
    parameter int unsigned W = 1
) (
    input  wire logic         pclk,
    input  wire logic         presetn,
    input  wire logic [W-1:0] din,
    output logic      [W-1:0] dout
);
    logic [W-1:0] stage1;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    stage1[i] <= 1'b0;
                    dout[i]   <= 1'b0;
                end else begin
                    stage1[i] <= din[i];
                    dout[i]   <= stage1[i];
                end
            end
        end
    endgenerate
endmodule : cps_sync

/* core/cps_protect.sv */
// cell protection state machine with apb register access
`timescale 1ns/100ps
module cps_protect #(
    parameter int unsigned TICK_DIV  = cps_pkg::TICK_CYCLES,
    parameter int unsigned TRIP_BASE = cps_pkg::TRIP_CYCLES
) (
    input  wire logic               pclk,
    input  wire logic               presetn,
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [7:0]         paddr,
    input  wire logic [31:0]        pwdata,
    output logic      [31:0]        prdata,
    output logic                    pready,
    output logic                    pslverr,
    input  wire cps_pkg::cps_sense_t sense_in,
    output cps_pkg::cps_sw_t        switch_mode,
    output logic                    high_cell_flag_n,
    output logic                    low_cell_flag_n,
    output logic                    pack_disable_out,
    output logic                    low_charge_warn,
    output logic                    sleep_mode,
    output logic                    irq
);
    cps_pkg::cps_sense_t  sense;
    cps_pkg::cps_state_t  state;
    cps_pkg::cps_state_t  next_state;
    logic [31:0]          tick_cnt;
    logic                 tick;
    logic [cps_pkg::QUAL_W-1:0] ov_cnt;
    logic [cps_pkg::QUAL_W-1:0] uv_cnt;
    logic                 ov_qual;
    logic                 uv_qual;
    logic [cps_pkg::TRIP_W-1:0] trip_cnt;
    logic                 trip_fire;
    logic                 any_over;
    logic                 any_under;
    logic                 split_fault;
    logic                 both_below_rec;
    logic                 both_above_warn;
    logic                 charger_seen;
    logic                 latch_rst_n;
    logic [31:0]          ctrl;
    logic [15:0]          trip_ext;
    logic [cps_pkg::EV_N-1:0] irq_stat;
    logic [cps_pkg::EV_N-1:0] irq_mask;
    logic [cps_pkg::EV_N-1:0] events;
    logic                 warn_raw;
    logic                 warn_d;
    logic                 inhibit;
    logic                 wr_en;
    logic                 rd_en;

    // synchronised sensing
    cps_sync #(
        .W       (cps_pkg::SENSE_W)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .din     (sense_in),
        .dout    (sense)
    );

    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a == cps_pkg::ADDR_CTRL) || (a == cps_pkg::ADDR_STATUS) ||
                   (a == cps_pkg::ADDR_IRQ_STAT) || (a == cps_pkg::ADDR_IRQ_MASK) ||
                   (a == cps_pkg::ADDR_TRIP_EXT);
    endfunction : addr_hit

    assign inhibit         = !sense.assembly_en || ctrl[cps_pkg::CTRL_FORCE_OFF];
    assign any_over        = |sense.above_over;
    assign any_under       = |sense.below_under;
    assign split_fault     = (sense.above_over[0] && sense.below_under[1]) ||
                             (sense.above_over[1] && sense.below_under[0]);
    assign both_below_rec  = ~|sense.above_rec;
    assign both_above_warn = ~|sense.below_warn;
    assign ov_qual         = (ov_cnt >= cps_pkg::QUAL_W'(cps_pkg::OV_QUAL_TICKS));
    assign uv_qual         = (uv_cnt >= cps_pkg::QUAL_W'(cps_pkg::UV_QUAL_TICKS));

    // internal oscillator tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b0;
        end else if (tick_cnt >= TICK_DIV - 1) begin
            tick_cnt <= 32'h0000_0000;
            tick     <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 32'h0000_0001;
            tick     <= 1'b0;
        end
    end

    // persistence qualification of over and under voltage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ov_cnt <= '0;
            uv_cnt <= '0;
        end else begin
            if (!any_over) begin
                ov_cnt <= '0;
            end else if (tick && !ov_qual) begin
                ov_cnt <= ov_cnt + 1'b1;
            end
            if (!any_under) begin
                uv_cnt <= '0;
            end else if (tick && !uv_qual) begin
                uv_cnt <= uv_cnt + 1'b1;
            end
        end
    end

    // overcurrent trip delay, extended by trip_ext
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trip_cnt  <= '0;
            trip_fire <= 1'b0;
        end else if (!sense.overcurrent || state == cps_pkg::ST_TRIP) begin
            trip_cnt  <= '0;
            trip_fire <= 1'b0;
        end else if (trip_cnt >= cps_pkg::TRIP_W'(TRIP_BASE) + cps_pkg::TRIP_W'(trip_ext) - 1'b1) begin
            trip_fire <= 1'b1;
        end else begin
            trip_cnt  <= trip_cnt + 1'b1;
        end
    end

    // next state
    always_comb begin
        next_state = state;
        case (state)
            cps_pkg::ST_NORMAL: begin
                if (trip_fire) begin
                    next_state = cps_pkg::ST_TRIP;
                end else if (tick && split_fault && ov_qual && uv_qual) begin
                    next_state = cps_pkg::ST_BOTH;
                end else if (tick && ov_qual) begin
                    next_state = cps_pkg::ST_OVER;
                end else if (tick && uv_qual) begin
                    next_state = cps_pkg::ST_UNDER;
                end
            end
            cps_pkg::ST_OVER: begin
                if (trip_fire) begin
                    next_state = cps_pkg::ST_TRIP;
                end else if (tick && split_fault && uv_qual) begin
                    next_state = cps_pkg::ST_BOTH;
                end else if (tick && both_below_rec) begin
                    next_state = cps_pkg::ST_NORMAL;
                end
            end
            cps_pkg::ST_UNDER: begin
                if (trip_fire) begin
                    next_state = cps_pkg::ST_TRIP;
                end else if (tick && split_fault && ov_qual) begin
                    next_state = cps_pkg::ST_BOTH;
                end else if (tick && both_above_warn) begin
                    next_state = cps_pkg::ST_NORMAL;
                end
            end
            cps_pkg::ST_BOTH: begin
                if (tick && !any_over && !any_under) begin
                    next_state = cps_pkg::ST_NORMAL;
                end
            end
            cps_pkg::ST_TRIP: begin
                if (tick && !sense.load_present) begin
                    next_state = cps_pkg::ST_NORMAL;
                end
            end
            default: begin
                next_state = cps_pkg::ST_NORMAL;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= cps_pkg::ST_NORMAL;
        end else if (!sense.assembly_en) begin
            state <= cps_pkg::ST_NORMAL;
        end else begin
            state <= next_state;
        end
    end

    // sleep until a charger is seen in over-discharge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charger_seen <= 1'b0;
        end else if (state != cps_pkg::ST_UNDER) begin
            charger_seen <= 1'b0;
        end else if (sense.charger_present) begin
            charger_seen <= 1'b1;
        end
    end

    // decoded outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_mode      <= cps_pkg::SW_OFF;
            high_cell_flag_n <= 1'b1;
            low_cell_flag_n  <= 1'b1;
            sleep_mode       <= 1'b0;
        end else begin
            high_cell_flag_n <= !(state == cps_pkg::ST_OVER || state == cps_pkg::ST_BOTH);
            low_cell_flag_n  <= !(state == cps_pkg::ST_UNDER || state == cps_pkg::ST_BOTH);
            sleep_mode       <= (state == cps_pkg::ST_UNDER) && !charger_seen;
            if (inhibit) begin
                switch_mode <= cps_pkg::SW_OFF;
            end else begin
                case (state)
                    cps_pkg::ST_NORMAL: switch_mode <= cps_pkg::SW_BOTH;
                    cps_pkg::ST_OVER:   switch_mode <= cps_pkg::SW_DISCHARGE;
                    cps_pkg::ST_UNDER:  switch_mode <= cps_pkg::SW_CHARGE;
                    cps_pkg::ST_BOTH:   switch_mode <= cps_pkg::SW_OFF;
                    cps_pkg::ST_TRIP:   switch_mode <= cps_pkg::SW_OFF;
                    default:            switch_mode <= cps_pkg::SW_OFF;
                endcase
            end
        end
    end

    // low charge warning, dropped in over-discharge
    assign warn_raw = (|sense.below_warn) && (state == cps_pkg::ST_NORMAL) && sense.assembly_en;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            low_charge_warn <= 1'b0;
            warn_d          <= 1'b0;
        end else begin
            low_charge_warn <= warn_raw;
            warn_d          <= warn_raw;
        end
    end

    // pack-disable latch, cleared straight from the enable pin
    assign latch_rst_n = presetn & sense_in.assembly_en;

    always_ff @(posedge pclk or negedge latch_rst_n) begin
        if (!latch_rst_n) begin
            pack_disable_out <= 1'b0;
        end else if (sense.assembly_en && next_state == cps_pkg::ST_OVER && state != cps_pkg::ST_OVER) begin
            pack_disable_out <= 1'b1;
        end
    end

    // interrupt events
    always_comb begin
        events = '0;
        events[cps_pkg::EV_OVERCHARGE] = (state != cps_pkg::ST_OVER) && (next_state == cps_pkg::ST_OVER);
        events[cps_pkg::EV_UNDER]      = (state != cps_pkg::ST_UNDER) && (next_state == cps_pkg::ST_UNDER);
        events[cps_pkg::EV_BOTH]       = (state != cps_pkg::ST_BOTH) && (next_state == cps_pkg::ST_BOTH);
        events[cps_pkg::EV_TRIP]       = (state != cps_pkg::ST_TRIP) && (next_state == cps_pkg::ST_TRIP);
        events[cps_pkg::EV_WARN]       = warn_raw && !warn_d;
        // no events while the assembly hold pins the state
        if (!sense.assembly_en) begin
            events = '0;
        end
    end

    // apb access
    assign wr_en   = psel && penable && pwrite;
    assign rd_en   = psel && penable && !pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl     <= cps_pkg::CTRL_RESET;
            trip_ext <= cps_pkg::TRIP_EXT_RESET;
            irq_mask <= cps_pkg::MASK_RESET;
        end else if (wr_en) begin
            case (paddr)
                cps_pkg::ADDR_CTRL:     ctrl     <= {31'h0000_0000, pwdata[cps_pkg::CTRL_FORCE_OFF]};
                cps_pkg::ADDR_TRIP_EXT: trip_ext <= pwdata[15:0];
                cps_pkg::ADDR_IRQ_MASK: irq_mask <= pwdata[cps_pkg::EV_N-1:0];
                default: begin
                end
            endcase
        end
    end

    // sticky status, read clears, a new event wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= '0;
        end else if (rd_en && paddr == cps_pkg::ADDR_IRQ_STAT) begin
            irq_stat <= events;
        end else begin
            irq_stat <= irq_stat | events;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(irq_stat & irq_mask);
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                cps_pkg::ADDR_CTRL:     prdata <= ctrl;
                cps_pkg::ADDR_STATUS:   prdata <= {20'h00000, switch_mode, sleep_mode, low_charge_warn,
                                                   pack_disable_out, low_cell_flag_n, high_cell_flag_n, state};
                cps_pkg::ADDR_IRQ_STAT: prdata <= {27'h0000000, irq_stat | events};
                cps_pkg::ADDR_IRQ_MASK: prdata <= {27'h0000000, irq_mask};
                cps_pkg::ADDR_TRIP_EXT: prdata <= {16'h0000, trip_ext};
                default:                prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule : cps_protect

/* test/cps_protect_asserts.sv */
// assertions on the ports of the protection state machine
`timescale 1ns/100ps
module cps_protect_asserts #(
    parameter int unsigned TICK_DIV  = cps_pkg::TICK_CYCLES,
    parameter int unsigned TRIP_BASE = cps_pkg::TRIP_CYCLES
) (
    input wire logic                pclk,
    input wire logic                presetn,
    input wire logic                psel,
    input wire logic                penable,
    input wire logic                pwrite,
    input wire logic [7:0]          paddr,
    input wire logic [31:0]         pwdata,
    input wire logic [31:0]         prdata,
    input wire logic                pready,
    input wire logic                pslverr,
    input wire cps_pkg::cps_sense_t sense_in,
    input wire cps_pkg::cps_sw_t    switch_mode,
    input wire logic                high_cell_flag_n,
    input wire logic                low_cell_flag_n,
    input wire logic                pack_disable_out,
    input wire logic                low_charge_warn,
    input wire logic                sleep_mode,
    input wire logic                irq
);
    logic [15:0] oc_cnt;

    // run length of raw overcurrent
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_cnt <= 16'h0000;
        end else if (!sense_in.overcurrent) begin
            oc_cnt <= 16'h0000;
        end else if (oc_cnt != 16'hFFFF) begin
            oc_cnt <= oc_cnt + 16'h0001;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_hold_off; !sense_in.assembly_en [*5] |-> switch_mode == cps_pkg::SW_OFF; endproperty
    a_hold_off: assert property (p_hold_off) else $error("switch not off in assembly hold");
    property p_latch_clr; !sense_in.assembly_en |-> !pack_disable_out; endproperty
    a_latch_clr: assert property (p_latch_clr) else $error("disable latch set in assembly hold");
    property p_latch_set; $rose(pack_disable_out) |=> !high_cell_flag_n; endproperty
    a_latch_set: assert property (p_latch_set) else $error("disable without overcharge flag");
    property p_latch_hold; pack_disable_out |=> pack_disable_out || !sense_in.assembly_en; endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("disable latch dropped");
    property p_over_sw;
        !high_cell_flag_n && low_cell_flag_n |-> switch_mode inside {cps_pkg::SW_DISCHARGE, cps_pkg::SW_OFF};
    endproperty
    a_over_sw: assert property (p_over_sw) else $error("charge allowed in overcharge");
    property p_under_sw;
        high_cell_flag_n && !low_cell_flag_n |-> switch_mode inside {cps_pkg::SW_CHARGE, cps_pkg::SW_OFF};
    endproperty
    a_under_sw: assert property (p_under_sw) else $error("discharge allowed in under state");
    property p_warn; low_charge_warn |-> high_cell_flag_n && low_cell_flag_n; endproperty
    a_warn: assert property (p_warn) else $error("warning outside normal state");
    property p_both; !high_cell_flag_n && !low_cell_flag_n |-> switch_mode == cps_pkg::SW_OFF; endproperty
    a_both: assert property (p_both) else $error("switch not off on split fault");
    property p_sleep; sleep_mode |-> high_cell_flag_n && !low_cell_flag_n; endproperty
    a_sleep: assert property (p_sleep) else $error("sleep outside under state");
    property p_trip;
        $past(switch_mode) == cps_pkg::SW_BOTH && switch_mode == cps_pkg::SW_OFF && high_cell_flag_n
            && low_cell_flag_n && $past(sense_in.overcurrent) |-> $past(oc_cnt) >= TRIP_BASE;
    endproperty
    a_trip: assert property (p_trip) else $error("overcurrent trip too early");
    property p_unmapped; psel && penable && paddr > 8'h10 |-> pslverr; endproperty
    a_unmapped: assert property (p_unmapped) else $error("no error on unmapped access");

    c_over: cover property ($rose(pack_disable_out));
    c_sleep: cover property ($rose(sleep_mode));
    c_both: cover property (!high_cell_flag_n && !low_cell_flag_n);
endmodule : cps_protect_asserts

bind cps_protect cps_protect_asserts #(.TICK_DIV(TICK_DIV), .TRIP_BASE(TRIP_BASE)) u_cps_protect_asserts (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_in(sense_in),
    .switch_mode(switch_mode), .high_cell_flag_n(high_cell_flag_n), .low_cell_flag_n(low_cell_flag_n),
    .pack_disable_out(pack_disable_out), .low_charge_warn(low_charge_warn), .sleep_mode(sleep_mode),
    .irq(irq));

/* test/cps_pack_model.sv */
// cells, series switch and pack terminals
`timescale 1ns/100ps
module cps_pack_model #(
    parameter int OVER_MV  = 4250,
    parameter int REC_MV   = 3750,
    parameter int WARN_MV  = 3000,
    parameter int UNDER_MV = 2500
) (
    input  wire logic [15:0]      mv0,
    input  wire logic [15:0]      mv1,
    input  wire logic             short_load,
    input  wire logic             load_on,
    input  wire logic             charger_on,
    input  wire logic             enable,
    input  wire cps_pkg::cps_sw_t switch_mode,
    output cps_pkg::cps_sense_t   sense
);
    always_comb begin
        sense.above_over  = {mv1 > OVER_MV, mv0 > OVER_MV};
        sense.above_rec   = {mv1 >= REC_MV, mv0 >= REC_MV};
        sense.below_warn  = {mv1 < WARN_MV, mv0 < WARN_MV};
        sense.below_under = {mv1 < UNDER_MV, mv0 < UNDER_MV};
        // short draws current only through a conducting switch
        sense.overcurrent = short_load && switch_mode inside {cps_pkg::SW_BOTH, cps_pkg::SW_DISCHARGE};
        sense.load_present    = load_on || short_load;
        sense.charger_present = charger_on;
        sense.assembly_en     = enable;
    end
endmodule : cps_pack_model

/* test/cps_protect_test.sv */
// self-checking bench for the protection state machine
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin errors++; \
    $display("Error %0t got %h expected %h", $time, (a), (b)); end end
module cps_protect_test;
    logic                pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]          paddr;
    logic [31:0]         pwdata, prdata, rd, seed;
    logic [15:0]         mv0, mv1;
    logic                short_load, load_on, charger_on, enable;
    logic                high_cell_flag_n, low_cell_flag_n, pack_disable_out, low_charge_warn, sleep_mode, irq;
    cps_pkg::cps_sense_t sense;
    cps_pkg::cps_sw_t    switch_mode;
    int                  errors, tests_run, n;

    cps_protect #(.TICK_DIV(8), .TRIP_BASE(20)) u_cps_protect (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .sense_in(sense),
        .switch_mode(switch_mode), .high_cell_flag_n(high_cell_flag_n), .low_cell_flag_n(low_cell_flag_n),
        .pack_disable_out(pack_disable_out), .low_charge_warn(low_charge_warn), .sleep_mode(sleep_mode),
        .irq(irq));
    cps_pack_model u_cps_pack_model (.mv0(mv0), .mv1(mv1), .short_load(short_load), .load_on(load_on),
        .charger_on(charger_on), .enable(enable), .switch_mode(switch_mode), .sense(sense));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // switch mode expected from the two flags
    function automatic cps_pkg::cps_sw_t sw_of(input logic hf, input logic lf);
        return cps_pkg::cps_sw_t'({hf, lf});
    endfunction : sw_of

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic expect_state(input logic hf, input logic lf, input logic warn, input int pre);
        int k;
        k = 0;
        repeat (pre) @(posedge pclk);
        while ((high_cell_flag_n !== hf || low_cell_flag_n !== lf) && k < 400) begin
            @(posedge pclk);
            k++;
        end
        repeat (2) @(posedge pclk);
        `CHK(high_cell_flag_n, hf)
        `CHK(low_cell_flag_n, lf)
        `CHK(switch_mode, sw_of(hf, lf))
        `CHK(low_charge_warn, warn)
    endtask : expect_state

    task automatic end_test(input string name);
        $display("done %s", name);
    endtask : end_test

    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : close_out

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    initial begin
        repeat (20000) @(posedge pclk);
        errors++;
        close_out();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {short_load, charger_on, load_on, enable} = 4'h3;
        {seed, errors, tests_run} = {32'h9E1DA959, 64'h0};
        {mv0, mv1} = {16'd3600, 16'd3600};
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, cps_pkg::ADDR_CTRL, 32'h0);
        `CHK(rd, cps_pkg::CTRL_RESET)
        apb(1'b0, cps_pkg::ADDR_IRQ_MASK, 32'h0);
        `CHK(rd[4:0], cps_pkg::MASK_RESET)
        apb(1'b0, cps_pkg::ADDR_TRIP_EXT, 32'h0);
        `CHK(rd[15:0], cps_pkg::TRIP_EXT_RESET)
        apb(1'b0, 8'h3C, 32'h0);
        `CHK({err, rd}, 33'h100000000)
        apb(1'b1, cps_pkg::ADDR_IRQ_MASK, 32'h0000_0002);
        end_test("registers");
        for (int i = 0; i < 4; i++) begin
            mv0 <= 16'(3100 + rnd() % 1100);
            mv1 <= 16'(3100 + rnd() % 1100);
            expect_state(1'b1, 1'b1, 1'b0, 40);
        end
        mv1 <= 16'(2600 + rnd() % 300);
        expect_state(1'b1, 1'b1, 1'b1, 40);
        mv0 <= 16'(2000 + rnd() % 490);
        expect_state(1'b1, 1'b0, 1'b0, 0);
        `CHK({sleep_mode, irq}, 2'h3)
        apb(1'b0, cps_pkg::ADDR_IRQ_STAT, 32'h0);
        `CHK(rd[cps_pkg::EV_UNDER], 1'b1)
        repeat (2) @(posedge pclk);
        `CHK(irq, 1'b0)
        charger_on <= 1'b1;
        repeat (40) @(posedge pclk);
        `CHK(sleep_mode, 1'b0)
        {mv0, mv1} <= {16'd2900, 16'd3100};
        expect_state(1'b1, 1'b0, 1'b0, 240);
        mv0 <= 16'd3100;
        expect_state(1'b1, 1'b1, 1'b0, 0);
        charger_on <= 1'b0;
        end_test("under");
        mv1 <= 16'd4300;
        repeat (80) @(posedge pclk);
        mv1 <= 16'd3700;
        expect_state(1'b1, 1'b1, 1'b0, 200);
        `CHK(pack_disable_out, 1'b0)
        mv1 <= 16'(4260 + rnd() % 200);
        expect_state(1'b0, 1'b1, 1'b0, 0);
        `CHK(pack_disable_out, 1'b1)
        apb(1'b0, cps_pkg::ADDR_STATUS, 32'h0);
        `CHK(rd, 32'h0000_04C2)
        mv1 <= 16'd3800;
        expect_state(1'b0, 1'b1, 1'b0, 240);
        mv1 <= 16'd3700;
        expect_state(1'b1, 1'b1, 1'b0, 0);
        `CHK(pack_disable_out, 1'b1)
        enable <= 1'b0;
        #2;
        `CHK(pack_disable_out, 1'b0)
        repeat (6) @(posedge pclk);
        `CHK(switch_mode, cps_pkg::SW_OFF)
        enable <= 1'b1;
        expect_state(1'b1, 1'b1, 1'b0, 40);
        end_test("overcharge");
        {mv0, mv1} <= {16'd4300, 16'd2400};
        expect_state(1'b0, 1'b0, 1'b0, 0);
        {mv0, mv1} <= {16'd3600, 16'd3600};
        expect_state(1'b1, 1'b1, 1'b0, 0);
        end_test("split fault");
        apb(1'b1, cps_pkg::ADDR_TRIP_EXT, 32'h0000_0010);
        short_load <= 1'b1;
        repeat (32) @(posedge pclk);
        `CHK(switch_mode, cps_pkg::SW_BOTH)
        n = 0;
        while (switch_mode !== cps_pkg::SW_OFF && n < 20) begin
            @(posedge pclk);
            n++;
        end
        `CHK(switch_mode, cps_pkg::SW_OFF)
        short_load <= 1'b0;
        repeat (80) @(posedge pclk);
        `CHK(switch_mode, cps_pkg::SW_OFF)
        load_on <= 1'b0;
        expect_state(1'b1, 1'b1, 1'b0, 40);
        load_on <= 1'b1;
        end_test("overcurrent");
        apb(1'b1, cps_pkg::ADDR_CTRL, 32'h0000_0001);
        repeat (4) @(posedge pclk);
        `CHK(switch_mode, cps_pkg::SW_OFF)
        apb(1'b1, cps_pkg::ADDR_CTRL, 32'h0);
        expect_state(1'b1, 1'b1, 1'b0, 8);
        end_test("force off");
        close_out();
    end
endmodule : cps_protect_test
